// File: logic/ctar_pkg.sv
// Package: constants and types for the cross-trigger arm router
package ctar_pkg;

  // Arm source selections
  typedef enum logic [2:0] {
    CTAR_ARM_ALWAYS,
    CTAR_ARM_A_HIGH,
    CTAR_ARM_B_HIGH,
    CTAR_ARM_A_LOW,
    CTAR_ARM_B_LOW
  } ctar_arm_e;

  // Trigger output selections
  typedef enum logic [1:0] {
    CTAR_OUT_NONE,
    CTAR_OUT_A,
    CTAR_OUT_B
  } ctar_out_e;

  // Interval result status
  typedef enum logic [1:0] {
    CTAR_IV_UNKNOWN,
    CTAR_IV_VALID,
    CTAR_IV_UNDER,
    CTAR_IV_OVER
  } ctar_iv_e;

  // Register map
  localparam int CTAR_AW = 4;
  localparam logic [3:0] CTAR_REG_EMU_ARM = 4'h0;
  localparam logic [3:0] CTAR_REG_EXT_ARM = 4'h1;
  localparam logic [3:0] CTAR_REG_EMU_OUT = 4'h2;
  localparam logic [3:0] CTAR_REG_EXT_OUT = 4'h3;
  localparam logic [3:0] CTAR_REG_BREAK = 4'h4;
  localparam logic [3:0] CTAR_REG_MODE = 4'h5;
  localparam logic [3:0] CTAR_REG_EMU_STAT = 4'h6;
  localparam logic [3:0] CTAR_REG_EXT_STAT = 4'h7;
  localparam logic [3:0] CTAR_REG_EMU_IVAL = 4'h8;
  localparam logic [3:0] CTAR_REG_EXT_IVAL = 4'h9;
  localparam logic [3:0] CTAR_REG_QUAL = 4'hA;

  // Qualifier slots; all but the count slot may carry the armed term
  localparam int CTAR_QS_PRI = 0;
  localparam int CTAR_QS_SEC = 1;
  localparam int CTAR_QS_STO = 2;
  localparam int CTAR_QS_PRE = 3;
  localparam int CTAR_QS_TRG = 4;
  localparam int CTAR_QS_CNT = 5;
  localparam int CTAR_NQ = 6;

  // Status field positions
  localparam int CTAR_ST_IGN = 0;
  localparam int CTAR_ST_RCV = 1;
  localparam int CTAR_ST_IV0 = 2;

  // Interval timing
  localparam real CTAR_CLK_MHZ = 200.0;
  localparam real CTAR_IV_MIN_US = 0.04;
  localparam real CTAR_IV_MAX_MS = 41.943;
  localparam int CTAR_IV_MIN_CYC = (CTAR_IV_MIN_US * CTAR_CLK_MHZ) < 1.0 ? 1 :
    int'($ceil(CTAR_IV_MIN_US * CTAR_CLK_MHZ));
  localparam int CTAR_IV_MAX_CYC = int'($floor(CTAR_IV_MAX_MS * 1000.0 * CTAR_CLK_MHZ));
  localparam int CTAR_IV_W = 24;

endpackage : ctar_pkg

// File: logic/ctar_router.sv
// Cross-trigger arm router between the two trace analyzers
//
// Implementation choices: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps

// Notes on behaviour
// - Arm defaults to always after reset
// - Arm source always, A/B high, A/B low
// - External arm select only in independent mode
// - Armed term usable in branch, store qualifiers
// - Armed term rejected in count qualifier
// - Status shows arm ignored or received
// - Received flag clears on start unless arm is present then, sets later
// - Measure arm-to-trigger, flag under or over
// - Interval unknown if always or trigger absent
// - No line driven after reset
// - Emulation trigger output selectable, readable back
// - External trigger output selected independently
// - Lines fan to outside, break, other arm
// - Per-line break enable forces monitor entry
// - Line causing break is released
// - Other line stays until halt or start
// - Analyzers cross-arm in independent mode
// - Armed term selectable as trigger qualifier
// - Mutual arming only in independent mode
module ctar_router
  import ctar_pkg::*;
#(
  parameter int IV_MAX_CYC = CTAR_IV_MAX_CYC
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic [CTAR_AW-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [1:0] trace_start,
  input wire logic [1:0] trace_halt,
  input wire logic [1:0] trig_found,
  input wire logic [1:0] trig_in_mem,
  input wire logic break_done,
  output logic cross_line_a,
  output logic cross_line_b,
  output logic break_req,
  output logic [1:0] armed,
  output logic [1:0] arm_in_trig_q
);

  // ==========================================================
  // Reset release
  logic rst_m_r;
  logic rst_n_r;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_m_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_m_r <= 1'b1;
      rst_n_r <= rst_m_r;
    end
  end

  // ==========================================================
  // Configuration registers
  ctar_arm_e arm_sel_r [2];
  ctar_out_e out_sel_r [2];
  logic [1:0] break_condition_enable_r;
  logic indep_r;
  logic [CTAR_NQ-1:0] qual_r [2];
  logic [31:0] rdata_nxt;
  logic wr_emu_arm;
  logic wr_ext_arm;
  logic wr_emu_out;
  logic wr_ext_out;
  logic wr_brk;
  logic wr_mode;
  logic wr_qual;

  assign wr_emu_arm = reg_wr && reg_addr == CTAR_REG_EMU_ARM;
  assign wr_ext_arm = reg_wr && reg_addr == CTAR_REG_EXT_ARM;
  assign wr_emu_out = reg_wr && reg_addr == CTAR_REG_EMU_OUT;
  assign wr_ext_out = reg_wr && reg_addr == CTAR_REG_EXT_OUT;
  assign wr_brk = reg_wr && reg_addr == CTAR_REG_BREAK;
  assign wr_mode = reg_wr && reg_addr == CTAR_REG_MODE;
  assign wr_qual = reg_wr && reg_addr == CTAR_REG_QUAL;

  // Arm source selects
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      arm_sel_r[0] <= CTAR_ARM_ALWAYS;
      arm_sel_r[1] <= CTAR_ARM_ALWAYS;
    end else if (clk_en) begin
      if (wr_emu_arm && reg_wdata[2:0] <= 3'(CTAR_ARM_B_LOW)) begin
        arm_sel_r[0] <= ctar_arm_e'(reg_wdata[2:0]);
      end
      if (wr_ext_arm && indep_r && reg_wdata[2:0] <= 3'(CTAR_ARM_B_LOW)) begin
        arm_sel_r[1] <= ctar_arm_e'(reg_wdata[2:0]);
      end
    end
  end

  // Trigger output selects
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      out_sel_r[0] <= CTAR_OUT_NONE;
      out_sel_r[1] <= CTAR_OUT_NONE;
    end else if (clk_en) begin
      if (wr_emu_out && reg_wdata[1:0] <= 2'(CTAR_OUT_B)) begin
        out_sel_r[0] <= ctar_out_e'(reg_wdata[1:0]);
      end
      if (wr_ext_out && reg_wdata[1:0] <= 2'(CTAR_OUT_B)) begin
        out_sel_r[1] <= ctar_out_e'(reg_wdata[1:0]);
      end
    end
  end

  // Break enables
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      break_condition_enable_r <= 2'h0;
    end else if (clk_en && wr_brk) begin
      break_condition_enable_r <= reg_wdata[1:0];
    end
  end

  // Analyzer mode
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      indep_r <= 1'b0;
    end else if (clk_en && wr_mode) begin
      indep_r <= reg_wdata[0];
    end
  end

  // Qualifier arm terms
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      qual_r[0] <= '0;
      qual_r[1] <= '0;
    end else if (clk_en && wr_qual) begin
      // count slot never takes the armed term
      qual_r[0] <= reg_wdata[CTAR_NQ-1:0] & ~(CTAR_NQ'(1) << CTAR_QS_CNT);
      qual_r[1] <= reg_wdata[CTAR_NQ+7:8] & ~(CTAR_NQ'(1) << CTAR_QS_CNT);
    end
  end

  // ==========================================================
  // Line drive and break release
  logic [1:0] drv_r [2];
  logic [1:0] line_w;
  logic [1:0] brk_r;

  assign line_w = drv_r[0] | drv_r[1];

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_an
      logic [1:0] drv_nxt;
      logic [1:0] sel_mask;
      logic eff_indep;
      logic arm_raw;
      logic rcv_r;
      logic cnt_on_r;
      logic [CTAR_IV_W-1:0] cnt_r;
      ctar_iv_e iv_r;
      logic [CTAR_IV_W-1:0] ival_r;

      assign sel_mask = out_sel_r[g] == CTAR_OUT_A ? 2'h1 :
                        out_sel_r[g] == CTAR_OUT_B ? 2'h2 : 2'h0;
      assign eff_indep = (g == 0) ? 1'b1 : indep_r;

      always_comb begin
        drv_nxt = drv_r[g];
        if (trace_start[g] || trace_halt[g]) begin
          drv_nxt = 2'h0;
        end else if (trig_found[g] && eff_indep) begin
          drv_nxt = drv_r[g] | sel_mask;
        end
        if (break_done) begin
          drv_nxt = drv_nxt & ~brk_r;
        end
      end

      always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
          drv_r[g] <= 2'h0;
        end else if (clk_en) begin
          drv_r[g] <= drv_nxt;
        end
      end

      // other analyzer arm from shared lines
      always_comb begin
        case (arm_sel_r[g])
          CTAR_ARM_ALWAYS: arm_raw = 1'b1;
          CTAR_ARM_A_HIGH: arm_raw = line_w[0];
          CTAR_ARM_B_HIGH: arm_raw = line_w[1];
          CTAR_ARM_A_LOW: arm_raw = !line_w[0];
          CTAR_ARM_B_LOW: arm_raw = !line_w[1];
          default: arm_raw = 1'b1;
        endcase
        if (!eff_indep && arm_sel_r[g] != CTAR_ARM_ALWAYS) begin
          arm_raw = 1'b0;
        end
      end

      // cleared on start unless arm is present then, set any time after
      always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
          rcv_r <= 1'b0;
        end else if (clk_en) begin
          if (arm_raw) begin
            rcv_r <= 1'b1;
          end else if (trace_start[g]) begin
            rcv_r <= 1'b0;
          end
        end
      end

      always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
          cnt_on_r <= 1'b0;
          cnt_r <= '0;
          iv_r <= CTAR_IV_UNKNOWN;
          ival_r <= '0;
        end else if (clk_en) begin
          if (trace_start[g]) begin
            cnt_on_r <= 1'b0;
            cnt_r <= '0;
            iv_r <= CTAR_IV_UNKNOWN;
          end else if (trig_found[g]) begin
            cnt_on_r <= 1'b0;
            ival_r <= cnt_r;
            // unknown if always or not in memory
            if (arm_sel_r[g] == CTAR_ARM_ALWAYS || !trig_in_mem[g] || !rcv_r) begin
              iv_r <= CTAR_IV_UNKNOWN;
            end else if (32'(cnt_r) < CTAR_IV_MIN_CYC) begin
              iv_r <= CTAR_IV_UNDER;
            end else if (32'(cnt_r) > IV_MAX_CYC) begin
              iv_r <= CTAR_IV_OVER;
            end else begin
              iv_r <= CTAR_IV_VALID;
            end
          end else if (arm_raw && !rcv_r) begin
            cnt_on_r <= 1'b1;
            cnt_r <= '0;
          end else if (cnt_on_r && cnt_r != '1) begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
      end

      always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
          armed[g] <= 1'b1;
          arm_in_trig_q[g] <= 1'b0;
        end else if (clk_en) begin
          armed[g] <= arm_raw | rcv_r;
          arm_in_trig_q[g] <= qual_r[g][CTAR_QS_TRG] & (arm_raw | rcv_r);
        end
      end
    end
  endgenerate

  // ==========================================================
  // Break request and outputs
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      brk_r <= 2'h0;
      break_req <= 1'b0;
    end else if (clk_en) begin
      brk_r <= line_w & break_condition_enable_r;
      break_req <= |(line_w & break_condition_enable_r);
    end
  end

  // Shared line outputs
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      cross_line_a <= 1'b0;
      cross_line_b <= 1'b0;
    end else if (clk_en) begin
      cross_line_a <= line_w[0];
      cross_line_b <= line_w[1];
    end
  end

  // ==========================================================
  // Read port
  // ignored or received status
  always_comb begin
    rdata_nxt = 32'h0;
    case (reg_addr)
      CTAR_REG_EMU_ARM: rdata_nxt[2:0] = arm_sel_r[0];
      CTAR_REG_EXT_ARM: rdata_nxt[2:0] = arm_sel_r[1];
      CTAR_REG_EMU_OUT: rdata_nxt[1:0] = out_sel_r[0];
      CTAR_REG_EXT_OUT: rdata_nxt[1:0] = out_sel_r[1];
      CTAR_REG_BREAK: rdata_nxt[1:0] = break_condition_enable_r;
      CTAR_REG_MODE: rdata_nxt[0] = indep_r;
      CTAR_REG_EMU_STAT: begin
        rdata_nxt[CTAR_ST_IGN] = arm_sel_r[0] == CTAR_ARM_ALWAYS;
        rdata_nxt[CTAR_ST_RCV] = g_an[0].rcv_r;
        rdata_nxt[CTAR_ST_IV0+1:CTAR_ST_IV0] = g_an[0].iv_r;
      end
      CTAR_REG_EXT_STAT: begin
        rdata_nxt[CTAR_ST_IGN] = arm_sel_r[1] == CTAR_ARM_ALWAYS;
        rdata_nxt[CTAR_ST_RCV] = g_an[1].rcv_r;
        rdata_nxt[CTAR_ST_IV0+1:CTAR_ST_IV0] = g_an[1].iv_r;
      end
      CTAR_REG_EMU_IVAL: rdata_nxt[CTAR_IV_W-1:0] = g_an[0].ival_r;
      CTAR_REG_EXT_IVAL: rdata_nxt[CTAR_IV_W-1:0] = g_an[1].ival_r;
      CTAR_REG_QUAL: begin
        rdata_nxt[CTAR_NQ-1:0] = qual_r[0];
        rdata_nxt[CTAR_NQ+7:8] = qual_r[1];
      end
      default: rdata_nxt = 32'h0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      reg_rdata <= 32'h0;
    end else if (clk_en) begin
      reg_rdata <= reg_rd ? rdata_nxt : 32'h0;
    end
  end

endmodule : ctar_router

// File: verif/ctar_router_asserts.sv
// Port checker of the cross-trigger arm router
`timescale 1ns/100ps
// ==========
// Checker
module ctar_router_asserts
  import ctar_pkg::*;
#(
  parameter int IV_MAX_CYC = 50
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [CTAR_AW-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [1:0] trace_start,
  input wire logic [1:0] trace_halt,
  input wire logic [1:0] trig_found,
  input wire logic break_done,
  input wire logic cross_line_a,
  input wire logic cross_line_b,
  input wire logic break_req,
  input wire logic [1:0] armed,
  input wire logic [1:0] arm_in_trig_q
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  a_rdata_idle: assert property (
    !$past(reg_rd) |-> reg_rdata == 32'h0) else $error("read data not idle");
  a_count_bit: assert property (
    $past(reg_rd) && $past(reg_addr) == CTAR_REG_QUAL |-> !reg_rdata[5] && !reg_rdata[13])
    else $error("count qualifier took arm");
  a_always_armed: assert property (
    reg_wr && reg_addr == CTAR_REG_EMU_ARM && reg_wdata == 32'h0 |-> ##2 armed[0])
    else $error("always source not armed");
  a_line_rise: assert property (
    $rose(cross_line_a) |-> $past(trig_found, 2) != 2'b00) else $error("line rose uncaused");
  a_line_fall: assert property (
    $fell(cross_line_a) |-> $past(break_done, 2) || $past(reg_wr, 2) ||
    $past(trace_start, 2) != 2'b00 || $past(trace_halt, 2) != 2'b00)
    else $error("line fell uncaused");
  a_break_src: assert property (
    break_req |-> cross_line_a || cross_line_b) else $error("break without line");
  a_break_release: assert property (
    break_done && trig_found == 2'b00 |-> ##[1:3] !break_req) else $error("break held");
  a_arm_qual: assert property (
    arm_in_trig_q != 2'b00 |-> (arm_in_trig_q & ~(armed | $past(armed))) == 2'b00)
    else $error("trigger arm without armed");
endmodule : ctar_router_asserts

// File: verif/ctar_partner.sv
// Model of the external analyzer trigger and the emulator break logic
`timescale 1ns/100ps
// ==========
// Partner model
module ctar_partner #(
  parameter int BRK_DLY = 6
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic fire,
  input wire logic break_req,
  output logic trig_ext,
  output logic break_done
);
  int cnt;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      trig_ext <= 1'b0;
      cnt <= 0;
      break_done <= 1'b0;
    end else begin
      trig_ext <= fire;
      cnt <= break_req ? cnt + 1 : 0;
      break_done <= break_req && cnt == BRK_DLY;
    end
  end
endmodule : ctar_partner

// File: verif/ctar_router_bench.sv
// Self-checking bench of the cross-trigger arm router
`timescale 1ns/100ps
// ==========
// Bench top
module ctar_router_bench
  import ctar_pkg::*;
;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic clk_en = 1'b1;
  logic [CTAR_AW-1:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [1:0] trace_start = 2'h0;
  logic [1:0] trace_halt = 2'h0;
  logic [1:0] trig_in_mem = 2'h0;
  logic trig_emu = 1'b0;
  logic fire = 1'b0;
  logic trig_ext;
  logic break_done;
  logic cross_line_a;
  logic cross_line_b;
  logic break_req;
  logic [1:0] armed;
  logic [1:0] arm_in_trig_q;
  wire logic [1:0] trig_found = {trig_ext, trig_emu};
  int err_count = 0;
  int compares = 0;
  logic [31:0] v = 32'h88FA76D7;
  logic [31:0] d;
  int gap[4] = '{3, 25, 80, 25};
  ctar_iv_e ivx[4] = '{CTAR_IV_UNDER, CTAR_IV_VALID, CTAR_IV_OVER, CTAR_IV_UNKNOWN};
  ctar_router #(.IV_MAX_CYC(50)) uut (.clk, .arst_n, .clk_en, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .trace_start, .trace_halt, .trig_found, .trig_in_mem, .break_done,
    .cross_line_a, .cross_line_b, .break_req, .armed, .arm_in_trig_q);
  ctar_partner #(.BRK_DLY(6)) peer (.clk, .arst_n, .fire, .break_req, .trig_ext, .break_done);
  always #2.5 clk = ~clk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [31:0] qual_exp(input logic [31:0] q);
    return q & 32'h1F1F;
  endfunction : qual_exp
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic wr(input logic [3:0] a, input logic [31:0] x);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= x;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    tick(1);
    reg_rd <= 1'b0;
    d = reg_rdata;
  endtask : rd
  task automatic pls(input logic [1:0] s, input logic [1:0] h, input logic e, input logic f);
    @(posedge clk);
    trace_start <= s;
    trace_halt <= h;
    trig_emu <= e;
    fire <= f;
    @(posedge clk);
    {trace_start, trace_halt, trig_emu, fire} <= 6'h0;
  endtask : pls
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    tick(20000);
    err_count++;
    report_and_stop;
  end
  initial begin
    tick(6);
    arst_n <= 1'b1;
    tick(3);
    chk(armed, 2'b11);
    chk({cross_line_a, cross_line_b, break_req}, 3'h0);
    for (int a = 0; a < 6; a++) begin
      rd(a[3:0]);
      chk(d, 32'h0);
    end
    rd(4'hF);
    chk(d, 32'h0);
    rd(CTAR_REG_EMU_STAT);
    chk(d[0], 1'b1);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      v = lfsr(v);
      wr(CTAR_REG_EMU_OUT, v % 3);
      rd(CTAR_REG_EMU_OUT);
      chk(d, v % 3);
      wr(CTAR_REG_QUAL, v);
      rd(CTAR_REG_QUAL);
      chk(d & 32'h3F3F, qual_exp(v));
      wr(CTAR_REG_EMU_ARM, v % 5);
    end
    wr(CTAR_REG_EMU_ARM, 32'h7);
    rd(CTAR_REG_EMU_ARM);
    chk(d, v % 5);
    wr(CTAR_REG_EXT_ARM, 32'h1);
    rd(CTAR_REG_EXT_ARM);
    chk(d, 32'h0);
    wr(CTAR_REG_MODE, 32'h1);
    wr(CTAR_REG_EXT_ARM, 32'h3);
    rd(CTAR_REG_EXT_ARM);
    chk(d, 32'h3);
    @(posedge clk);
    clk_en <= 1'b0;
    wr(CTAR_REG_MODE, 32'h0);
    @(posedge clk);
    clk_en <= 1'b1;
    rd(CTAR_REG_MODE);
    chk(d, 32'h1);
    $display("test registers done");
    wr(CTAR_REG_EXT_ARM, 32'h0);
    wr(CTAR_REG_EMU_ARM, 32'h1);
    wr(CTAR_REG_EXT_OUT, 32'h1);
    wr(CTAR_REG_EMU_OUT, 32'h2);
    wr(CTAR_REG_QUAL, 32'h10);
    wr(CTAR_REG_BREAK, 32'h1);
    pls(2'b01, 2'b00, 1'b0, 1'b0);
    pls(2'b10, 2'b00, 1'b0, 1'b0);
    tick(2);
    chk(armed[0], 1'b0);
    pls(2'b00, 2'b00, 1'b0, 1'b1);
    tick(6);
    chk({cross_line_a, break_req, armed[0], arm_in_trig_q[0]}, 4'hF);
    trig_in_mem <= 2'b11;
    pls(2'b00, 2'b00, 1'b1, 1'b0);
    tick(20);
    chk({cross_line_a, cross_line_b, break_req}, 3'b010);
    rd(CTAR_REG_EMU_STAT);
    chk(d[1], 1'b1);
    pls(2'b00, 2'b01, 1'b0, 1'b0);
    tick(3);
    chk(cross_line_b, 1'b0);
    $display("test cross arm done");
    wr(CTAR_REG_BREAK, 32'h0);
    wr(CTAR_REG_EMU_OUT, 32'h0);
    for (int k = 0; k < 4; k++) begin
      pls(2'b00, 2'b10, 1'b0, 1'b0);
      pls(2'b11, 2'b00, 1'b0, 1'b0);
      tick(3);
      pls(2'b00, 2'b00, 1'b0, 1'b1);
      for (int w = 0; w < 10 && cross_line_a !== 1'b1; w++) tick(1);
      trig_in_mem <= {1'b1, k != 3};
      tick(gap[k]);
      pls(2'b00, 2'b00, 1'b1, 1'b0);
      tick(3);
      rd(CTAR_REG_EMU_STAT);
      chk(d[3:2], ivx[k]);
    end
    $display("test interval done");
    pls(2'b00, 2'b10, 1'b0, 1'b0);
    wr(CTAR_REG_MODE, 32'h0);
    pls(2'b00, 2'b00, 1'b0, 1'b1);
    tick(4);
    chk(cross_line_a, 1'b0);
    wr(CTAR_REG_MODE, 32'h1);
    wr(CTAR_REG_EMU_OUT, 32'h1);
    pls(2'b00, 2'b00, 1'b1, 1'b1);
    tick(4);
    pls(2'b00, 2'b01, 1'b0, 1'b0);
    tick(3);
    chk(cross_line_a, 1'b1);
    pls(2'b00, 2'b10, 1'b0, 1'b0);
    tick(3);
    chk(cross_line_a, 1'b0);
    $display("test modes done");
    report_and_stop;
  end
endmodule : ctar_router_bench
bind ctar_router ctar_router_asserts #(.IV_MAX_CYC(IV_MAX_CYC)) chk_i (.clk, .arst_n,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .trace_start, .trace_halt, .trig_found,
  .break_done, .cross_line_a, .cross_line_b, .break_req, .armed, .arm_in_trig_q);
